/* File: src/speed_supervisor.v */
// speed command selection, skip bands, thermal, faults, cycle limiter
// assumes 24 V inputs arrive asynchronously; analog and temp come from
// converters on this clock; speeds are held in 0.01 Hz units
//
// Our own choices: the Wishbone register port and the register addresses.
`include "speed_supervisor_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module speed_supervisor #(
	parameter TICK_CYC = `TICK_CYC,
	parameter FLASH_TICKS = 500,
	parameter PAUSE_TICKS = 2000,
	parameter HOUR_TICKS = 3600000
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	input wire wb_we_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire low_speed_input_i,
	input wire high_speed_input_i,
	input wire select_input_i,
	input wire bypass_pins_i,
	input wire [9:0] analog_level_i,
	input wire [7:0] module_temp_i,
	input wire phase_order_fault_i,
	input wire phase_loss_i,
	input wire overcurrent_i,
	input wire input_volt_low_i,
	input wire input_volt_high_i,
	output reg motor_power_o,
	output reg [15:0] speed_cmd_o,
	output reg pwm_fold_o,
	output reg stage_trip_o,
	output reg fan_relay_o,
	output reg fault_led_o
);
	localparam [4:0] F_PHASE = 5'd1;
	localparam [4:0] F_LOSS = 5'd2;
	localparam [4:0] F_OC = 5'd3;
	localparam [4:0] F_VLOW = 5'd4;
	localparam [4:0] F_VHIGH = 5'd5;
	localparam [4:0] F_CYCLE = 5'd6;
	localparam [4:0] F_THERM = 5'd7;
	localparam [4:0] F_LOCK = 5'd17;
	localparam [1:0] L_IDLE = 2'd0;
	localparam [1:0] L_ON = 2'd1;
	localparam [1:0] L_OFF = 2'd2;
	localparam [1:0] L_PAUSE = 2'd3;
	localparam [15:0] HOLD_LAST = 1000 * `BYPASS_HOLD_S - 1;
	localparam [15:0] EDGE_WIN = 1000 * `BYPASS_EDGE_S;
	localparam [31:0] BYPASS_LEN = `BYPASS_MIN * 60 * 1000;
	localparam [15:0] FLASH_T = FLASH_TICKS;
	localparam [15:0] PAUSE_T = PAUSE_TICKS;

	// two-flop synchronisers for the 24 V inputs and bypass pins
	reg [3:0] sync1_q;
	reg [3:0] sync2_q;
	reg [3:0] prev_q;
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
			prev_q <= 4'h0;
		end else begin
			sync1_q <= {bypass_pins_i, select_input_i, high_speed_input_i,
				low_speed_input_i};
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end
	wire lo_s = sync2_q[0];
	wire hi_s = sync2_q[1];
	wire sel_s = sync2_q[2];
	wire byp_s = sync2_q[3];
	wire sel_edge = sync2_q[2] ^ prev_q[2];

	// millisecond tick from the system clock
	reg [31:0] tick_cnt_q;
	reg tick_q;
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			tick_cnt_q <= 32'h0;
			tick_q <= 1'b0;
		end else if (tick_cnt_q == TICK_CYC - 1) begin
			tick_cnt_q <= 32'h0;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h1;
			tick_q <= 1'b0;
		end
	end

	// registers
	reg [7:0] ctrl_q;
	reg [15:0] preset_q [0:6];
	reg [15:0] skip_lo_q [0:4];
	reg [15:0] skip_hi_q [0:4];
	reg [15:0] serial_cmd_q;
	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wb_wr = wb_req && wb_we_i;
	wire fault_clr = wb_wr && wb_adr_i == `ADR_CTRL && wb_sel_i[0] &&
		wb_dat_i[`CTRL_FAULT_CLR];
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi = gi + 1) begin : g_preset
			always @(posedge clk_i) begin
				if (!rst_n_i)
					preset_q[gi] <= `SPD_MIN_HZ;
				else if (wb_wr && wb_adr_i == `ADR_PRESET_BASE + 4 * gi) begin
					if (wb_sel_i[0])
						preset_q[gi][7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1])
						preset_q[gi][15:8] <= wb_dat_i[15:8];
				end
			end
		end
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_skip
			always @(posedge clk_i) begin
				if (!rst_n_i) begin
					skip_lo_q[gi] <= 16'h0;
					skip_hi_q[gi] <= 16'h0;
				end else if (wb_wr && wb_adr_i == `ADR_SKIP_BASE + 4 * gi) begin
					if (wb_sel_i[1:0] == 2'b11)
						skip_lo_q[gi] <= wb_dat_i[15:0];
					if (wb_sel_i[3:2] == 2'b11)
						skip_hi_q[gi] <= wb_dat_i[31:16];
				end
			end
		end
	endgenerate
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl_q <= `CTRL_RESET;
			serial_cmd_q <= 16'h0;
		end else begin
			if (wb_wr && wb_adr_i == `ADR_CTRL && wb_sel_i[0])
				ctrl_q <= {1'b0, wb_dat_i[6:0]};
			if (wb_wr && wb_adr_i == `ADR_SERIAL_CMD && wb_sel_i[1:0] == 2'b11)
				serial_cmd_q <= wb_dat_i[15:0];
		end
	end

	// raw speed request
	reg [15:0] req_hz;
	reg req_run;
	reg [2:0] code;
	always @* begin
		code = {sel_s, hi_s, lo_s};
		req_hz = 16'h0;
		req_run = 1'b0;
		if (ctrl_q[`CTRL_SERIAL]) begin
			req_hz = serial_cmd_q;
			req_run = serial_cmd_q != 16'h0;
		end else if (ctrl_q[`CTRL_ANALOG]) begin
			// 10 bits from 40 Hz in 0.08 Hz steps gives 8 Hz/100 steps, about 5 RPM
			req_hz = `SPD_MIN_HZ + {analog_level_i, 3'b000};
			req_run = lo_s;
		end else if (ctrl_q[`CTRL_BINARY]) begin
			req_run = code != 3'd0;
			if (code != 3'd0)
				req_hz = preset_q[code - 3'd1];
		end else if (ctrl_q[`CTRL_SHARED]) begin
			// presets 0,1 shared; 2 is heat boost
			req_run = lo_s || hi_s;
			req_hz = hi_s ? preset_q[1] : preset_q[0];
			if (sel_s && req_run)
				req_hz = preset_q[2];
		end else begin
			// sel picks heating pair 2,3 over cooling pair 0,1
			req_run = lo_s || hi_s;
			req_hz = preset_q[{sel_s, hi_s}];
		end
	end

	// envelope clamp; boost only with select and envelope flag
	wire boost_ok = sel_s && ctrl_q[`CTRL_ENVELOPE];
	wire [15:0] max_hz = boost_ok ? `SPD_BOOST_HZ : `SPD_MAX_HZ;
	reg [15:0] clamp_hz;
	reg [15:0] out_hz;
	integer k;
	always @* begin
		clamp_hz = req_hz;
		if (clamp_hz < `SPD_MIN_HZ)
			clamp_hz = `SPD_MIN_HZ;
		if (clamp_hz > max_hz)
			clamp_hz = max_hz;
		if (pwm_fold_o && clamp_hz > `SPD_MAX_HZ)
			clamp_hz = `SPD_MAX_HZ;
		out_hz = clamp_hz;
		// inside a band: settle on its lower edge, also during foldback
		if (out_hz > `SKIP_DEF_LO && out_hz < `SKIP_DEF_HI)
			out_hz = `SKIP_DEF_LO;
		for (k = 0; k < 5; k = k + 1)
			if (out_hz > skip_lo_q[k] && out_hz < skip_hi_q[k])
				out_hz = skip_lo_q[k];
	end

	// faults, restarts, cycle limiter
	reg [4:0] fault_q;
	reg [1:0] restarts_q;
	reg [31:0] restart_win_q;
	reg [2:0] starts_q;
	reg [31:0] hour_q;
	reg [31:0] bypass_q;
	reg [2:0] edges_q;
	reg [15:0] edge_win_q;
	reg [15:0] hold_q;
	wire hot_trip = module_temp_i >= `TEMP_TRIP_C;
	reg [4:0] new_fault;
	always @* begin
		new_fault = 5'd0;
		if (hot_trip)
			new_fault = F_THERM;
		else if (phase_order_fault_i)
			new_fault = F_PHASE;
		else if (phase_loss_i)
			new_fault = F_LOSS;
		else if (overcurrent_i)
			new_fault = F_OC;
		else if (input_volt_low_i)
			new_fault = F_VLOW;
		else if (input_volt_high_i)
			new_fault = F_VHIGH;
	end
	wire limit_on = ctrl_q[`CTRL_ANTI_SHORT_CYCLE_DELAY_EN] && bypass_q == 32'h0;
	wire run_ok = req_run && fault_q == 5'd0;
	wire start_req = run_ok && !motor_power_o;
	wire start_block = limit_on && starts_q >= `START_MAX;
	wire bypass_go = ctrl_q[`CTRL_HW_V1] ? (byp_s && hold_q ==
		HOLD_LAST && tick_q) :
		(sel_edge && edges_q == `BYPASS_EDGES - 1);
	wire power_on = start_req && !start_block && new_fault == 5'd0;
	wire power_off = !run_ok || new_fault != 5'd0;
	wire power_d = power_on || (motor_power_o && !power_off);
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			fault_q <= 5'd0;
			restarts_q <= 2'd0;
			restart_win_q <= 32'h0;
			starts_q <= 3'd0;
			hour_q <= 32'h0;
			bypass_q <= 32'h0;
			edges_q <= 3'd0;
			edge_win_q <= 16'h0;
			hold_q <= 16'h0;
			motor_power_o <= 1'b0;
			speed_cmd_o <= 16'h0;
			pwm_fold_o <= 1'b0;
			stage_trip_o <= 1'b0;
			fan_relay_o <= 1'b0;
		end else begin
			pwm_fold_o <= module_temp_i > `TEMP_FOLD_C;
			stage_trip_o <= hot_trip;
			if (new_fault != 5'd0 && fault_q != F_LOCK) begin
				// auto restart budget; fourth fault locks out
				if (restarts_q == `RESTART_MAX)
					fault_q <= F_LOCK;
				else
					fault_q <= new_fault;
			end else if (start_req && start_block) begin
				fault_q <= F_CYCLE;
			end else if (fault_clr || (fault_q != F_LOCK && fault_q !=
				5'd0 && new_fault == 5'd0)) begin
				if (fault_q != 5'd0 && fault_q != F_LOCK && !fault_clr)
					restarts_q <= restarts_q + 2'd1;
				fault_q <= 5'd0;
				if (fault_clr)
					restarts_q <= 2'd0;
			end
			if (tick_q) begin
				if (restart_win_q == 6 * HOUR_TICKS - 1) begin
					restart_win_q <= 32'h0;
					restarts_q <= 2'd0;
				end else
					restart_win_q <= restart_win_q + 32'h1;
				if (hour_q == HOUR_TICKS - 1) begin
					hour_q <= 32'h0;
					starts_q <= 3'd0;
				end else
					hour_q <= hour_q + 32'h1;
				if (bypass_q != 32'h0)
					bypass_q <= bypass_q - 32'h1;
				hold_q <= byp_s ? hold_q + 16'h1 : 16'h0;
				if (edge_win_q != 16'h0)
					edge_win_q <= edge_win_q - 16'h1;
				else
					edges_q <= 3'd0;
			end
			if (sel_edge) begin
				edges_q <= edges_q + 3'd1;
				if (edges_q == 3'd0)
					edge_win_q <= EDGE_WIN;
			end
			if (bypass_go) begin
				bypass_q <= BYPASS_LEN;
				edges_q <= 3'd0;
			end
			if (power_on) begin
				motor_power_o <= 1'b1;
				fan_relay_o <= 1'b1;
				if (starts_q != 3'd7)
					starts_q <= starts_q + 3'd1;
			end else if (power_off) begin
				motor_power_o <= 1'b0;
				fan_relay_o <= 1'b0;
			end
			// speed moves in step with power, so a stopped drive shows zero
			speed_cmd_o <= power_d ? out_hz : 16'h0;
		end
	end

	// led flasher: burst of code flashes, then a long dark pause
	reg [1:0] led_st_q;
	reg [15:0] led_t_q;
	reg [4:0] led_n_q;
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			led_st_q <= L_IDLE;
			led_t_q <= 16'h0;
			led_n_q <= 5'd0;
			fault_led_o <= 1'b0;
		end else if (fault_q == 5'd0) begin
			led_st_q <= L_IDLE;
			fault_led_o <= 1'b0;
		end else if (tick_q || led_st_q == L_IDLE) begin
			case (led_st_q)
				L_IDLE: begin
					led_st_q <= L_ON;
					led_n_q <= fault_q;
					led_t_q <= FLASH_T;
					fault_led_o <= 1'b1;
				end
				L_ON: if (led_t_q == 16'h0) begin
					led_st_q <= L_OFF;
					led_t_q <= FLASH_T;
					fault_led_o <= 1'b0;
					led_n_q <= led_n_q - 5'd1;
				end else
					led_t_q <= led_t_q - 16'h1;
				L_OFF: if (led_t_q == 16'h0) begin
					led_st_q <= (led_n_q == 5'd0) ? L_PAUSE : L_ON;
					led_t_q <= (led_n_q == 5'd0) ? PAUSE_T : FLASH_T;
					fault_led_o <= led_n_q != 5'd0;
				end else
					led_t_q <= led_t_q - 16'h1;
				L_PAUSE: if (led_t_q == 16'h0)
					led_st_q <= L_IDLE;
				else
					led_t_q <= led_t_q - 16'h1;
				default: led_st_q <= L_IDLE;
			endcase
		end
	end

	// wishbone read and one-cycle ack
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0;
			if (wb_req && !wb_we_i) begin
				if (wb_adr_i == `ADR_CTRL)
					wb_dat_o <= {24'h0, ctrl_q};
				else if (wb_adr_i >= `ADR_PRESET_BASE &&
					wb_adr_i < `ADR_PRESET_BASE + 8'd28 && wb_adr_i[1:0] == 2'b00)
					wb_dat_o <= {16'h0, preset_q[wb_adr_i[4:2] - 3'd1]};
				else if (wb_adr_i >= `ADR_SKIP_BASE &&
					wb_adr_i < `ADR_SKIP_BASE + 8'd20 && wb_adr_i[1:0] == 2'b00)
					wb_dat_o <= {skip_hi_q[wb_adr_i[4:2]], skip_lo_q[wb_adr_i[4:2]]};
				else if (wb_adr_i == `ADR_STATUS)
					wb_dat_o <= {18'h0, restarts_q, starts_q, bypass_q != 32'h0,
						pwm_fold_o, stage_trip_o, fan_relay_o, motor_power_o,
						sync2_q};
				else if (wb_adr_i == `ADR_SPEED)
					wb_dat_o <= {16'h0, speed_cmd_o};
				else if (wb_adr_i == `ADR_SERIAL_CMD)
					wb_dat_o <= {16'h0, serial_cmd_q};
				else if (wb_adr_i == `ADR_FAULT)
					wb_dat_o <= {27'h0, fault_q};
			end
		end
	end
endmodule
`default_nettype wire

/* File: src/speed_supervisor_defines.vh */
// constants for the compressor speed supervisor
// assumes a 200 MHz clock; long times are scaled down through parameters
`ifndef SPEED_SUPERVISOR_DEFINES_VH
`define SPEED_SUPERVISOR_DEFINES_VH
`define CLK_MHZ 200
`define ADR_CTRL 8'h00
`define ADR_PRESET_BASE 8'h04
`define ADR_SKIP_BASE 8'h20
`define ADR_STATUS 8'h40
`define ADR_SPEED 8'h44
`define ADR_SERIAL_CMD 8'h48
`define ADR_FAULT 8'h4C
`define CTRL_ANALOG 0
`define CTRL_SERIAL 1
`define CTRL_BINARY 2
`define CTRL_SHARED 3
`define CTRL_ANTI_SHORT_CYCLE_DELAY_EN 4
`define CTRL_HW_V1 5
`define CTRL_ENVELOPE 6
`define CTRL_FAULT_CLR 7
`define CTRL_RESET 8'h10
`define SPD_MIN_HZ 16'd4000
`define SPD_MAX_HZ 16'd12000
`define SPD_BOOST_HZ 16'd16000
`define SKIP_DEF_LO 16'd8600
`define SKIP_DEF_HI 16'd9400
`define TEMP_FOLD_C 8'd80
`define TEMP_TRIP_C 8'd115
`define ANALOG_HZ_STEP 16'd1
`define NUM_FAULTS 17
`define RESTART_MAX 3
`define START_MAX 6
`define BYPASS_EDGES 6
`define BYPASS_EDGE_S 10
`define BYPASS_HOLD_S 2
`define BYPASS_MIN 30
`define TICK_US 1000
`define TICK_CYC (`TICK_US * `CLK_MHZ)
`endif

/* File: sim/speed_supervisor_asserts.sv */
// port checker for speed_supervisor
// bound to every instance; one clock domain, synchronous reset
`timescale 1ns/10ps
`default_nettype none
module speed_supervisor_asserts (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic [7:0] module_temp_i,
	input wire logic motor_power_o,
	input wire logic [15:0] speed_cmd_o,
	input wire logic pwm_fold_o,
	input wire logic stage_trip_o,
	input wire logic fan_relay_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_answer;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_ack_after_take: assert property (s_take |=> s_answer)
		else $error("ack not a one cycle answer");
	a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_fan_is_power: assert property (fan_relay_o == motor_power_o)
		else $error("fan relay differs from motor power");
	a_stop_speed_zero: assert property (!motor_power_o |-> !speed_cmd_o)
		else $error("speed while stopped");
	a_speed_in_range: assert property (motor_power_o |->
		speed_cmd_o >= 16'h0FA0 && speed_cmd_o <= 16'h3E80)
		else $error("speed out of range");
	a_default_skip: assert property (motor_power_o |->
		!(speed_cmd_o > 16'h2198 && speed_cmd_o < 16'h24B8))
		else $error("speed inside default band");
	a_fold_when_hot: assert property (module_temp_i > 8'h50 |-> ##[1:2] pwm_fold_o)
		else $error("no foldback above 80");
	a_fold_when_cool: assert property ((module_temp_i <= 8'h50)[*3] |-> !pwm_fold_o)
		else $error("foldback at or below 80");
	a_trip_when_hot: assert property (module_temp_i >= 8'h73 |-> ##[1:2] stage_trip_o)
		else $error("no trip at 115");
	a_trip_cuts_power: assert property ($rose(stage_trip_o) |-> ##[0:3] !motor_power_o)
		else $error("power kept after trip");
endmodule
bind speed_supervisor speed_supervisor_asserts chk (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .module_temp_i(module_temp_i),
	.motor_power_o(motor_power_o), .speed_cmd_o(speed_cmd_o),
	.pwm_fold_o(pwm_fold_o), .stage_trip_o(stage_trip_o),
	.fan_relay_o(fan_relay_o));
`default_nettype wire

/* File: sim/unit_controller_model.sv */
// unit controller model: drives the three 24 V level inputs and the bypass pins
// assumes the bench picks the code just after a clock edge
`timescale 1ns/10ps
`default_nettype none
module unit_controller_model (
	input wire logic [2:0] code_i,
	input wire logic pins_short_i,
	output wire logic low_speed_input_o,
	output wire logic high_speed_input_o,
	output wire logic select_input_o,
	output wire logic bypass_pins_o
);
	// code bits {select, high, low}; all low is a stop request except in serial mode
	assign low_speed_input_o = code_i[0];
	assign high_speed_input_o = code_i[1];
	assign select_input_o = code_i[2];
	assign bypass_pins_o = pins_short_i;
endmodule
`default_nettype wire

/* File: sim/speed_supervisor_tb.sv */
// self-checking bench for speed_supervisor
// drives wishbone and levels; partner model makes the 24 V lines
`timescale 1ns/10ps
`default_nettype none
`include "speed_supervisor_defines.vh"
module speed_supervisor_tb;
	logic clk_i = 0, rst_n_i = 0, cyc = 0, stb = 0, we = 0, short = 0;
	logic [7:0] adr = 0, temp = 8'h19;
	logic [31:0] dat = 0, rd;
	logic [3:0] sel = 0;
	logic [9:0] lvl = 0;
	logic [2:0] code = 0;
	logic [4:0] flt = 0;
	wire logic [31:0] dat_o;
	wire logic [15:0] spd;
	wire logic ack, lo, hi, sl, bp, pwr, fold, trip, fan, led;
	int mismatches = 0, checked = 0;
	initial forever #2.5 clk_i = ~clk_i;
	unit_controller_model ucm (.code_i(code), .pins_short_i(short),
		.low_speed_input_o(lo), .high_speed_input_o(hi),
		.select_input_o(sl), .bypass_pins_o(bp));
	// short tick and hour give a 2000-cycle limiter window that holds all t_limit starts
	speed_supervisor #(.TICK_CYC(2), .FLASH_TICKS(2), .PAUSE_TICKS(8),
		.HOUR_TICKS(1000)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.low_speed_input_i(lo), .high_speed_input_i(hi),
		.select_input_i(sl), .bypass_pins_i(bp), .analog_level_i(lvl),
		.module_temp_i(temp), .phase_order_fault_i(flt[0]),
		.phase_loss_i(flt[1]), .overcurrent_i(flt[2]),
		.input_volt_low_i(flt[3]), .input_volt_high_i(flt[4]),
		.motor_power_o(pwr), .speed_cmd_o(spd), .pwm_fold_o(fold),
		.stage_trip_o(trip), .fan_relay_o(fan), .fault_led_o(led));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		for (n = 0; n < 40 && ack !== 1'b1; n++) @(posedge clk_i);
		rd = dat_o;
		if (n == 40) begin
			mismatches++;
			$display("[ERR] %0t bus answer missing", $time);
		end
		cyc <= 0;
		stb <= 0;
	endtask
	// settle time covers the input synchroniser and the speed path
	task go(input logic [2:0] c, input logic [31:0] e);
		code <= c;
		repeat (24) @(posedge clk_i);
		chk(spd, e);
	endtask
	task t_reset;
		wb(0, `ADR_CTRL, 0);
		chk(rd, 32'h10);
		wb(0, `ADR_PRESET_BASE, 0);
		chk(rd, 32'hFA0);
		wb(0, `ADR_SKIP_BASE, 0);
		chk(rd, 0);
		wb(0, 8'h80, 0);
		chk(rd, 0);
		chk(pwr, 0);
	endtask
	task t_limit;
		int i;
		for (i = 0; i < 7; i++) begin
			code <= 1;
			repeat (24) @(posedge clk_i);
			chk(pwr, i < 6);
			code <= 0;
			repeat (24) @(posedge clk_i);
		end
		wb(1, `ADR_CTRL, 32'h80);
	endtask
	task t_presets;
		logic [2:0] cs [4] = '{1, 2, 5, 6};
		int k;
		for (k = 0; k < 7; k++) wb(1, `ADR_PRESET_BASE + 8'(4 * k), 32'h1000 + 32'(256 * k));
		for (k = 0; k < 4; k++) go(cs[k], 32'h1000 + 32'(256 * k));
		go(0, 0);
		wb(1, `ADR_CTRL, 32'h04);
		for (k = 1; k < 8; k++) go(3'(k), 32'h1000 + 32'(256 * (k - 1)));
		go(0, 0);
	endtask
	task t_boost;
		wb(1, `ADR_CTRL, 32'h08);
		wb(1, `ADR_PRESET_BASE + 8'h08, 32'h36B0);
		go(3'b101, 32'h2EE0);
		wb(1, `ADR_CTRL, 32'h48);
		go(3'b101, 32'h36B0);
		go(3'b001, 32'h1000);
		go(0, 0);
	endtask
	task t_skip;
		wb(1, `ADR_CTRL, 32'h00);
		wb(1, `ADR_SKIP_BASE + 8'h10, 32'h17701388);
		wb(1, `ADR_PRESET_BASE, 32'h157C);
		go(1, 32'h1388);
		wb(1, `ADR_PRESET_BASE, 32'h2328);
		go(1, 32'h2198);
		go(0, 0);
	endtask
	task t_serial;
		wb(1, `ADR_CTRL, 32'h02);
		wb(1, `ADR_SERIAL_CMD, 32'h10E1);
		go(0, 32'h10E1);
		wb(1, `ADR_SERIAL_CMD, 0);
		go(0, 0);
	endtask
	task t_analog;
		wb(1, `ADR_CTRL, 32'h01);
		lvl <= 10'd100;
		go(1, 32'h12C0);
		go(0, 0);
	endtask
	task t_fault;
		int seen;
		seen = 0;
		wb(1, `ADR_CTRL, 32'h80);
		go(1, 32'h2198);
		flt <= 5'h04;
		repeat (8) @(posedge clk_i);
		wb(0, `ADR_FAULT, 0);
		chk(rd, 3);
		chk(pwr, 0);
		chk(fan, 0);
		repeat (16) @(posedge clk_i) if (led === 1'b1) seen++;
		chk(32'(seen != 0), 1);
		flt <= 0;
		go(0, 0);
	endtask
	task t_temp;
		wb(1, `ADR_CTRL, 32'h80);
		code <= 1;
		temp <= 8'd81;
		repeat (24) @(posedge clk_i);
		chk(fold, 1);
		chk(fan, 1);
		temp <= 8'd80;
		repeat (6) @(posedge clk_i);
		chk(fold, 0);
		temp <= 8'd115;
		repeat (6) @(posedge clk_i);
		chk(trip, 1);
		chk(pwr, 0);
		temp <= 8'h19;
		code <= 0;
	endtask
	task give_verdict;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1;
		t_reset();
		t_limit();
		t_presets();
		t_boost();
		t_skip();
		t_serial();
		t_analog();
		t_fault();
		t_temp();
		give_verdict();
	end
	// the whole sequence needs well under 20000 cycles
	initial begin
		#100000;
		mismatches++;
		$display("[ERR] %0t run did not finish", $time);
		give_verdict();
	end
endmodule
`default_nettype wire
